/* File: src/serial_transceiver_defines.svh */
// Register offsets, field positions, reset values and timing for the serial transceiver
`ifndef SERIAL_TRANSCEIVER_DEFINES_SVH
`define SERIAL_TRANSCEIVER_DEFINES_SVH

// Register byte offsets (low five address bits)
`define ADDR_CTRL    5'h00
`define ADDR_BAUD    5'h04
`define ADDR_TXDATA  5'h08
`define ADDR_RXDATA  5'h0c
`define ADDR_STATUS  5'h10

// Status bit positions
`define ST_TXBUF_EMPTY  0
`define ST_SHIFT_EMPTY  1
`define ST_RX_READY     2
`define ST_OVERRUN      3
`define ST_FRAMING      4
`define ST_WAKE         5
`define ST_ABD_DONE     6

// Reset values
`define CTRL_RESET   12'h000
`define BAUD_RESET   16'h0000

// Break length in bit periods and receive buffer depth in characters
`define BREAK_BITS   4'hd
`define RX_DEPTH     2'h2

`endif

/* File: src/serial_transceiver_pkg.sv */
// Types shared by the serial transceiver
package serial_transceiver_pkg;

  // Control register layout, bit 0 is txEnable
  typedef struct packed {
    logic serialEnable;
    logic sendBreak;
    logic wakeEnable;
    logic autoBaud;
    logic brg16;
    logic polInvert;
    logic master;
    logic syncMode;
    logic addrDetect;
    logic nineBit;
    logic rxEnable;
    logic txEnable;
  } ctrl_t;

  typedef enum logic [2:0] {RX_IDLE, RX_MEASURE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // Whole state of the transceiver
  typedef struct packed {
    ctrl_t            ctrl;
    logic [15:0]      baudDiv;
    logic [8:0]       txHold;
    logic             txHoldFull;
    logic [8:0]       txShift;
    logic             txBusy;
    logic             txBreak;
    logic [3:0]       txIdx;
    logic [15:0]      txCnt;
    logic             txLine;
    logic             clkLine;
    rx_state_t        rxState;
    logic [15:0]      rxCnt;
    logic [3:0]       rxIdx;
    logic [8:0]       rxShift;
    logic             rxPrev;
    logic             clkPrev;
    logic [1:0][8:0]  rxMem;
    logic [1:0]       rxCount;
    logic             rxRd;
    logic             overrun;
    logic             framing;
    logic             wake;
    logic             abdDone;
    logic             wrPend;
    logic [4:0]       wrAddr;
    logic [31:0]      rdData;
  } state_t;

endpackage

/* File: src/async_serial_transceiver.sv */
// Serial transceiver: async NRZ and sync framing, baud generator, AHB-Lite registers
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "serial_transceiver_defines.svh"

module async_serial_transceiver
  import serial_transceiver_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial pins
  input  wire logic        rxIn,
  output logic             txOut,
  output logic             txOe,
  input  wire logic        clkIn,
  output logic             clkOut,
  output logic             clkOe
);

  state_t      st;
  state_t      next_st;
  logic [15:0] div;
  logic        addrPhase;
  logic        rxPush;
  logic        rxFerr;
  logic [8:0]  rxChar;
  logic [3:0]  dataBits;
  logic [3:0]  txLast;
  logic        clkRise;
  logic [8:0]  rxHead;
  logic [8:0]  status;

  // Divider width follows brg16; the upper byte is ignored in 8-bit mode
  assign div = st.ctrl.brg16 ? st.baudDiv : {8'h00, st.baudDiv[7:0]};
  assign dataBits = st.ctrl.nineBit ? 4'h9 : 4'h8;
  assign addrPhase = hsel && htrans[1] && hready;
  assign rxHead = st.rxMem[st.rxRd];
  assign clkRise = (clkIn ^ st.ctrl.polInvert) && !(st.clkPrev ^ st.ctrl.polInvert);

  // Status word seen by software
  always_comb begin
    status = 9'h000;
    status[`ST_TXBUF_EMPTY] = st.ctrl.txEnable && !st.txHoldFull;
    status[`ST_SHIFT_EMPTY] = !st.txBusy;
    status[`ST_RX_READY] = st.rxCount != 2'h0;
    status[`ST_OVERRUN] = st.overrun;
    status[`ST_FRAMING] = st.framing;
    status[`ST_WAKE] = st.wake;
    status[`ST_ABD_DONE] = st.abdDone;
  end

  // Bus outputs: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdData;
  assign txOut = st.txLine;
  assign clkOut = st.clkLine;
  assign txOe = st.ctrl.serialEnable && st.ctrl.txEnable;
  assign clkOe = st.ctrl.serialEnable && st.ctrl.syncMode && st.ctrl.master;

  // Next-state logic for bus, transmitter and receiver
  always_comb begin
    next_st = st;
    rxPush = 1'b0;
    rxFerr = 1'b0;
    rxChar = st.rxShift;
    txLast = st.txBreak ? `BREAK_BITS : (st.ctrl.syncMode ? dataBits - 4'h1 : dataBits + 4'h1);
    next_st.rxPrev = rxIn;
    next_st.clkPrev = clkIn;

    // Bus data phase: writes land one cycle after their address phase
    next_st.wrPend = addrPhase && hwrite;
    if (addrPhase) begin
      next_st.wrAddr = haddr[4:0];
    end
    if (st.wrPend) begin
      unique case (st.wrAddr)
        `ADDR_CTRL: next_st.ctrl = ctrl_t'(hwdata[11:0]);
        `ADDR_BAUD: next_st.baudDiv = hwdata[15:0];
        `ADDR_TXDATA: begin
          // Writes into a full holding register are dropped
          if (!st.txHoldFull) begin
            next_st.txHold = hwdata[8:0];
            next_st.txHoldFull = 1'b1;
          end
        end
        `ADDR_STATUS: begin
          // Write one to clear; hardware sets below take priority
          if (hwdata[`ST_OVERRUN]) next_st.overrun = 1'b0;
          if (hwdata[`ST_FRAMING]) next_st.framing = 1'b0;
          if (hwdata[`ST_WAKE]) next_st.wake = 1'b0;
          if (hwdata[`ST_ABD_DONE]) next_st.abdDone = 1'b0;
        end
        default: ;
      endcase
    end

    // Read data registered in the address phase; reading RXDATA pops
    if (addrPhase && !hwrite) begin
      unique case (haddr[4:0])
        `ADDR_CTRL: next_st.rdData = {20'h00000, st.ctrl};
        `ADDR_BAUD: next_st.rdData = {16'h0000, st.baudDiv};
        `ADDR_RXDATA: next_st.rdData = {23'h000000, rxHead};
        `ADDR_STATUS: next_st.rdData = {23'h000000, status};
        default: next_st.rdData = 32'h00000000;
      endcase
      if (haddr[4:0] == `ADDR_RXDATA && st.rxCount != 2'h0) begin
        next_st.rxRd = !st.rxRd;
        next_st.rxCount = st.rxCount - 2'h1;
      end
    end

    // Transmitter: load holding register the cycle after the shifter frees
    if (!st.txBusy) begin
      if (st.txHoldFull && st.ctrl.txEnable && st.ctrl.serialEnable) begin
        next_st.txShift = st.txHold;
        next_st.txHoldFull = 1'b0;
        next_st.txBusy = 1'b1;
        next_st.txBreak = st.ctrl.sendBreak && !st.ctrl.syncMode;
        next_st.txIdx = 4'h0;
        next_st.txCnt = div;
      end
    end else if (st.txCnt == 16'h0000) begin
      // Runs to the end on its own once loaded
      if (st.txIdx == txLast) begin
        next_st.txBusy = 1'b0;
        if (st.txBreak) next_st.ctrl.sendBreak = 1'b0;
      end else begin
        next_st.txIdx = st.txIdx + 4'h1;
        next_st.txCnt = div;
      end
    end else begin
      next_st.txCnt = st.txCnt - 16'h0001;
    end

    // Line level from the next frame position
    if (!next_st.txBusy) begin
      next_st.txLine = 1'b1;
    end else if (next_st.txBreak) begin
      next_st.txLine = next_st.txIdx >= `BREAK_BITS;
    end else if (st.ctrl.syncMode) begin
      next_st.txLine = next_st.txShift[next_st.txIdx];
    end else if (next_st.txIdx == 4'h0) begin
      next_st.txLine = 1'b0;
    end else if (next_st.txIdx <= dataBits) begin
      next_st.txLine = next_st.txShift[next_st.txIdx - 4'h1];
    end else begin
      next_st.txLine = 1'b1;
    end
    // Inversion applies to async only; sync uses the bit as clock polarity.
    // Taken from the next control word so a polarity write never leaves a
    // one-cycle space on an idle line.
    if (!next_st.ctrl.syncMode && next_st.ctrl.polInvert) begin
      next_st.txLine = !next_st.txLine;
    end
    // Sync master clock: first half of each bit idle, second half active
    next_st.clkLine = st.ctrl.polInvert ^ (next_st.txBusy && st.ctrl.syncMode &&
                      next_st.txCnt <= {1'b0, div[15:1]});

    // Receiver
    unique case (st.rxState)
      RX_IDLE: begin
        if (st.ctrl.rxEnable && st.ctrl.serialEnable) begin
          if (st.ctrl.syncMode && !st.ctrl.master) begin
            // Sync slave: shift on each active clock edge
            if (clkRise) begin
              next_st.rxShift[st.rxIdx] = rxIn;
              next_st.rxIdx = st.rxIdx + 4'h1;
              if (st.rxIdx == dataBits - 4'h1) begin
                rxPush = 1'b1;
                rxChar = next_st.rxShift;
                next_st.rxIdx = 4'h0;
              end
            end
          end else if (!st.ctrl.syncMode && st.rxPrev && !rxIn) begin
            next_st.rxShift = 9'h000;
            next_st.rxIdx = 4'h0;
            if (st.ctrl.autoBaud) begin
              next_st.rxState = RX_MEASURE;
              next_st.rxCnt = 16'h0000;
            end else begin
              next_st.rxState = RX_START;
              next_st.rxCnt = {1'b0, div[15:1]};
            end
          end
        end
      end
      RX_MEASURE: begin
        // Low time of the start bit, less the detecting cycle, becomes the new divider
        if (rxIn) begin
          next_st.baudDiv = st.rxCnt;
          next_st.ctrl.brg16 = 1'b1;
          next_st.ctrl.autoBaud = 1'b0;
          next_st.abdDone = 1'b1;
          next_st.rxState = RX_IDLE;
        end else if (st.rxCnt != 16'hffff) begin
          next_st.rxCnt = st.rxCnt + 16'h0001;
        end
      end
      RX_START: begin
        if (st.rxCnt != 16'h0000) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else if (rxIn) begin
          next_st.rxState = RX_IDLE; // Glitch, not a start bit
        end else begin
          next_st.rxState = RX_DATA;
          next_st.rxCnt = div;
        end
      end
      RX_DATA: begin
        if (st.rxCnt != 16'h0000) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else begin
          next_st.rxShift[st.rxIdx] = rxIn;
          next_st.rxIdx = st.rxIdx + 4'h1;
          next_st.rxCnt = div;
          if (st.rxIdx == dataBits - 4'h1) next_st.rxState = RX_STOP;
        end
      end
      RX_STOP: begin
        if (st.rxCnt != 16'h0000) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else begin
          next_st.rxState = RX_IDLE;
          rxFerr = !rxIn;
          // Address filter drops data characters; break is always kept
          rxPush = !(st.ctrl.addrDetect && st.ctrl.nineBit && !st.rxShift[8]) || rxFerr;
          if (st.ctrl.wakeEnable && rxFerr && st.rxShift == 9'h000) begin
            next_st.wake = 1'b1;
          end
        end
      end
      default: next_st.rxState = RX_IDLE;
    endcase
    if (rxFerr) next_st.framing = 1'b1;

    // Two-character receive buffer; a third character is lost unless a read pops one in the same cycle
    if (rxPush) begin
      if (next_st.rxCount == `RX_DEPTH) begin
        next_st.overrun = 1'b1;
      end else begin
        next_st.rxMem[next_st.rxRd ^ next_st.rxCount[0]] = rxChar;
        next_st.rxCount = next_st.rxCount + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= ctrl_t'(`CTRL_RESET);
      st.baudDiv <= `BAUD_RESET;
      st.txLine <= 1'b1;
      st.rxPrev <= 1'b1;
      st.rxState <= RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_idleMark;
    !st.txBusy && !st.ctrl.polInvert && !st.ctrl.syncMode |-> txOut;
  endproperty
  a_idleMark: assert property (p_idleMark) else $error("tx line not at mark when idle");

  property p_startSpace;
    $rose(st.txBusy) && !st.txBreak && !st.ctrl.syncMode && !st.ctrl.polInvert |-> !txOut;
  endproperty
  a_startSpace: assert property (p_startSpace) else $error("start bit not space");

  property p_bitHold;
    st.txBusy && $past(st.txBusy) && $past(st.txCnt) != 16'h0000 |-> $stable(st.txIdx);
  endproperty
  a_bitHold: assert property (p_bitHold) else $error("bit ended before its period");

  property p_release;
    !st.ctrl.txEnable |-> !txOe;
  endproperty
  a_release: assert property (p_release) else $error("tx pin driven while disabled");

  property p_load;
    !st.txBusy && st.txHoldFull && st.ctrl.txEnable && st.ctrl.serialEnable
      |=> st.txBusy && !st.txHoldFull;
  endproperty
  a_load: assert property (p_load) else $error("pending character not loaded");

  property p_shiftEmpty;
    $rose(st.txBusy) |-> $past(st.txHoldFull) && !status[`ST_SHIFT_EMPTY];
  endproperty
  a_shiftEmpty: assert property (p_shiftEmpty) else $error("shifter loaded from nothing");

  property p_overrun;
    rxPush && st.rxCount == `RX_DEPTH && !(addrPhase && !hwrite && haddr[4:0] == `ADDR_RXDATA)
      |=> st.overrun && st.rxCount == `RX_DEPTH;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_framing;
    st.rxState == RX_STOP && st.rxCnt == 16'h0000 && !rxIn |=> st.framing;
  endproperty
  a_framing: assert property (p_framing) else $error("framing error not flagged");

  property p_break;
    $rose(st.txBusy) && st.txBreak && !st.ctrl.polInvert |-> !txOut [*8];
  endproperty
  a_break: assert property (p_break) else $error("break line not held at space");

endmodule

/* File: verif/remote_station.sv */
// Remote serial station model: sends frames and decodes what the device transmits
`timescale 1ns/1ps

module remote_station (
  // Clock
  input  wire logic sys_clk,
  // Serial lines
  input  wire logic txLine,
  output logic      rxLine
);
  int         bitLen = 8;
  int         nbits  = 8;
  logic [8:0] gotQ[$];
  logic       stopQ[$];
  logic [8:0] word;

  // Line is pulled up, so it rests at mark between frames
  initial rxLine = 1'b1;

  // One frame, each bit held a whole period; call just after a clock edge
  task automatic sendChar(input logic [8:0] d, input logic stopLvl);
    rxLine <= 1'b0;
    repeat (bitLen) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      rxLine <= d[i];
      repeat (bitLen) @(posedge sys_clk);
    end
    rxLine <= stopLvl;  // Low only when a broken frame is wanted
    repeat (bitLen) @(posedge sys_clk);
    rxLine <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  // Decoder samples at bit centres; waits for mark again so a break is one frame
  always begin
    @(negedge txLine);
    repeat (bitLen / 2) @(posedge sys_clk);
    word = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (bitLen) @(posedge sys_clk);
      word[i] = txLine;
    end
    repeat (bitLen) @(posedge sys_clk);
    stopQ.push_back(txLine);
    gotQ.push_back(word);
    wait (txLine === 1'b1);
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the serial transceiver with a remote station on the line
`timescale 1ns/1ps
`include "serial_transceiver_defines.svh"

module tb_top;
  logic        sys_clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hreadyout;
  wire logic   hresp;
  wire logic   txOut;
  wire logic   txOe;
  wire logic   rxIn;
  wire logic   clkOut;
  wire logic   clkOe;
  wire logic [31:0] hrdata;
  int          numErrors = 0;
  int          testsRun = 0;
  int          n;

  async_serial_transceiver dut_u (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxIn(rxIn),
    .txOut(txOut), .txOe(txOe), .clkIn(1'b0), .clkOut(clkOut), .clkOe(clkOe));

  remote_station st_u (.sys_clk(sys_clk), .txLine(txOut), .rxLine(rxIn));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for hready; running out ends the run
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      numErrors++;
      giveVerdict();
    end
  endtask

  // Single word transfer: address phase, then data phase; read data taken at its end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask

  task automatic rdCheck(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic waitChars(input int cnt);
    int k;
    k = 0;
    while (st_u.gotQ.size() < cnt && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (st_u.gotQ.size() < cnt) begin
      numErrors++;
      giveVerdict();
    end
  endtask

  // Length of the next low stretch on txOut, sampled on falling edges where it is settled
  task automatic lowLen(output int len);
    int k;
    k = 0;
    len = 1;
    do begin
      @(negedge sys_clk);
      k++;
    end while (txOut !== 1'b0 && k < 100);
    do begin
      @(negedge sys_clk);
      if (txOut === 1'b0) len++;
    end while (txOut === 1'b0 && len < 500);
    @(posedge sys_clk);
  endtask

  task automatic testReset;
    check("idle txOut", txOut, 32'h1);
    check("txOe off", txOe, 32'h0);
    check("hresp", hresp, 32'h0);
    rdCheck("ctrl reset", `ADDR_CTRL, 32'h0);
    rdCheck("baud reset", `ADDR_BAUD, 32'h0);
    rdCheck("unmapped", 5'h14, 32'h0);
    // High byte kept but unused while the 8-bit divider is selected
    bus(1'b1, `ADDR_BAUD, 32'h0107);
    rdCheck("baud rw", `ADDR_BAUD, 32'h0107);
    $display("test reset done");
  endtask

  task automatic testTx;
    bus(1'b1, `ADDR_CTRL, 32'h803);
    @(negedge sys_clk);
    check("txOe on", txOe, 32'h1);
    @(posedge sys_clk);
    bus(1'b1, `ADDR_TXDATA, 32'ha5);
    bus(1'b1, `ADDR_TXDATA, 32'h3c);
    rdCheck("status busy", `ADDR_STATUS, 32'h0);
    waitChars(2);
    check("char one", st_u.gotQ[0], 32'ha5);
    check("char two", st_u.gotQ[1], 32'h3c);
    check("stops", {st_u.stopQ[0], st_u.stopQ[1]}, 32'h3);
    repeat (20) @(posedge sys_clk);
    rdCheck("status idle", `ADDR_STATUS, 32'h3);
    st_u.gotQ.delete();
    st_u.stopQ.delete();
    $display("test transmit done");
  endtask

  task automatic testRx;
    st_u.sendChar(9'h011, 1'b1);
    st_u.sendChar(9'h022, 1'b1);
    st_u.sendChar(9'h033, 1'b1);
    rdCheck("overrun set", `ADDR_STATUS, 32'h0f);
    rdCheck("rx first", `ADDR_RXDATA, 32'h11);
    rdCheck("rx second", `ADDR_RXDATA, 32'h22);
    rdCheck("rx drained", `ADDR_STATUS, 32'h0b);
    bus(1'b1, `ADDR_STATUS, 32'h08);
    rdCheck("overrun clr", `ADDR_STATUS, 32'h03);
    bus(1'b1, `ADDR_CTRL, 32'ha03);
    st_u.sendChar(9'h000, 1'b0);
    rdCheck("framing wake", `ADDR_STATUS, 32'h37);
    rdCheck("break char", `ADDR_RXDATA, 32'h0);
    bus(1'b1, `ADDR_STATUS, 32'h30);
    rdCheck("flags clr", `ADDR_STATUS, 32'h03);
    $display("test receive done");
  endtask

  task automatic testNine;
    bus(1'b1, `ADDR_CTRL, 32'h80f);
    st_u.nbits = 9;
    st_u.sendChar(9'h0a5, 1'b1);
    st_u.sendChar(9'h1a5, 1'b1);
    rdCheck("address char", `ADDR_RXDATA, 32'h1a5);
    rdCheck("data dropped", `ADDR_STATUS, 32'h03);
    bus(1'b1, `ADDR_TXDATA, 32'h1c3);
    waitChars(1);
    check("ninth bit tx", st_u.gotQ[0], 32'h1c3);
    st_u.gotQ.delete();
    st_u.stopQ.delete();
    st_u.nbits = 8;
    $display("test nine bit done");
  endtask

  task automatic testBreak;
    bus(1'b1, `ADDR_CTRL, 32'h803);
    bus(1'b1, `ADDR_TXDATA, 32'h01);
    lowLen(n);
    check("start length", n, 32'd8);
    waitChars(1);
    bus(1'b1, `ADDR_CTRL, 32'hc03);
    bus(1'b1, `ADDR_TXDATA, 32'h0);
    lowLen(n);
    check("break length", n, 32'd104);
    repeat (30) @(posedge sys_clk);
    rdCheck("break cleared", `ADDR_CTRL, 32'h803);
    $display("test break done");
  endtask

  // Auto baud: an all-ones character leaves only the start bit low to measure
  task automatic testAuto;
    bus(1'b1, `ADDR_CTRL, 32'h903);
    st_u.sendChar(9'h0ff, 1'b1);
    rdCheck("auto baud div", `ADDR_BAUD, 32'h7);
    rdCheck("auto baud ctrl", `ADDR_CTRL, 32'h883);
    rdCheck("auto baud done", `ADDR_STATUS, 32'h43);
    bus(1'b1, `ADDR_STATUS, 32'h40);
    rdCheck("auto done clr", `ADDR_STATUS, 32'h03);
    $display("test auto baud done");
  endtask

  // Last, since an inverted idle leaves the station waiting for mark
  task automatic testPol;
    bus(1'b1, `ADDR_CTRL, 32'h843);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("inverted idle", txOut, 32'h0);
    @(posedge sys_clk);
    bus(1'b1, `ADDR_CTRL, 32'h802);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("tx released", txOe, 32'h0);
    @(posedge sys_clk);
    // Sync master with inverted clock: clock pin driven, idling high
    bus(1'b1, `ADDR_CTRL, 32'h870);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("sync clock oe", clkOe, 32'h1);
    check("sync clock idle", clkOut, 32'h1);
    @(posedge sys_clk);
    $display("test polarity done");
  endtask

  // Main sequence: reset held two cycles, then the scenarios
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    testReset();
    testTx();
    testRx();
    testNine();
    testBreak();
    testAuto();
    testPol();
    giveVerdict();
  end
endmodule
